//--- design/timer_params.svh
// register offsets, field positions and reset values of the capture/compare timer
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH
`define OFS_CAP_A       8'h00
`define OFS_CAP_B       8'h04
`define OFS_CMP_A       8'h08
`define OFS_CMP_B       8'h0c
`define OFS_COUNTER     8'h10
`define OFS_MODE        8'h14
`define OFS_IRQ_PRE     8'h18
`define OFS_FLAGS       8'h1c
`define COUNTER_RELOAD  16'hfffc
`define COUNTER_TOP     16'hffff
`define CMP_A_RESET     16'h8000
`define MODE_RESET      16'h0000
`define IRQ_PRE_RESET   16'h0000
`define MODE_WR_MASK    16'hcfff
`define IRQ_PRE_WR_MASK 16'hf8ff
`define BIT_CAP_A       15
`define BIT_CMP_A       14
`define BIT_OVF         13
`define BIT_CAP_B       12
`define BIT_CMP_B       11
`endif

//--- design/timer_pkg.sv
// types shared by the capture/compare timer
package timer_pkg;
  typedef struct packed {
    logic       count_en;
    logic       pulse_measure_mode;
    logic [1:0] rsvd;
    logic       force_out_b;
    logic       force_out_a;
    logic       level_b;
    logic       level_a;
    logic       out_b_pin_enable;
    logic       out_a_pin_enable;
    logic       single_pulse_mode;
    logic       pwm_mode;
    logic       edge_select_b;
    logic       edge_select_a;
    logic       ext_clock_edge;
    logic       ext_clock_select;
  } mode_s;

  typedef struct packed {
    logic       cap_a_irq_en;
    logic       cmp_a_irq_en;
    logic       overflow_irq_en;
    logic       cap_b_irq_en;
    logic       cmp_b_irq_en;
    logic [2:0] rsvd;
    logic [7:0] prescale_factor;
  } irq_pre_s;

  typedef struct packed {
    logic       sel;
    logic       wr;
    logic [7:0] addr;
    logic [15:0] wdata;
  } reg_req_s;
endpackage

//--- design/capture_compare_timer_regs.sv
// 16-bit capture/compare timer with its register file
//
// What this block does
// - any counter write reloads FFFCh; reads return the live count
// - mode bit 15 gates counting on timer clocks
// - mode bit 14 enables pulse-width input measurement
// - writing 1 to force-B drives output B to level-B at once
// - writing 1 to force-A drives output A to level-A at once
// - compare-B match drives level-B to B, or to A in PWM mode; it drives neither in single-pulse mode
// - compare-A match drives level-A onto A whether or not output A is pin-enabled
// - pin-enable bits choose compare output versus general I/O on pins
// - single-pulse mode: selected edge on capture A starts one pulse
// - PWM mode: compare A sets pulse length, compare B sets period
// - edge-select bits pick falling or rising capture edges
// - external clock edge bit picks falling or rising counting edge
// - clock source bit picks prescaled internal or external clock
// - five interrupt enables request interrupts while matching flags are set
// - prescaler divides internal clock by field plus one
// - capture flags set on capture events, reset to zero
// - compare-A flag sets on match except in PWM mode
// - compare-B flag sets on every match, PWM included
// - overflow flag sets when counter wraps FFFFh to 0000h
// - writing 0 clears a flag, writing 1 leaves it
// - compare-B value continuously compared with the counter
// - capture registers latch the counter on their events, read-only
// - in PWM mode compare-B match reloads counter to FFFCh
// - measurement mode: capture A clears counter, first capture raises no interrupt
`include "timer_params.svh"
`timescale 1ns/10ps
`default_nettype none

module capture_compare_timer_regs (
  // clock, reset, clock enable
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  // register port, full 16-bit accesses only
  input  wire timer_pkg::reg_req_s  req,
  output var  logic [15:0]          rdata,
  // pins
  input  wire logic                 capture_in_a,
  input  wire logic                 capture_in_b,
  input  wire logic                 external_clock_in,
  output var  logic                 compare_out_a,
  output var  logic                 compare_out_b,
  output var  logic                 out_a_pin_sel,
  output var  logic                 out_b_pin_sel,
  // interrupt requests
  output var  logic                 irq_cap_a,
  output var  logic                 irq_cmp_a,
  output var  logic                 irq_overflow,
  output var  logic                 irq_cap_b,
  output var  logic                 irq_cmp_b
);
  import timer_pkg::*;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  mode_s       mode_reg;
  irq_pre_s    irqp_reg;
  logic [15:0] cap_a_reg;
  logic [15:0] cap_b_reg;
  logic [15:0] cmp_a_reg;
  logic [15:0] cmp_b_reg;
  logic [15:0] count_reg;
  logic [15:0] flags_reg;
  logic [7:0]  pre_reg;
  logic [2:0]  sync_a_reg;
  logic [2:0]  sync_b_reg;
  logic [2:0]  sync_x_reg;
  logic        out_a_reg;
  logic        out_b_reg;
  logic        pulse_run_reg;
  logic        first_cap_reg;
  logic        fa_keep_reg;

  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  // stage 0 is only read by stage 1; edges come from stages 1 and 2
  always_ff @(posedge clk) begin
    if (rst) begin
      sync_a_reg <= 3'h0;
      sync_b_reg <= 3'h0;
      sync_x_reg <= 3'h0;
    end else if (ce) begin
      sync_a_reg <= {sync_a_reg[1:0], capture_in_a};
      sync_b_reg <= {sync_b_reg[1:0], capture_in_b};
      sync_x_reg <= {sync_x_reg[1:0], external_clock_in};
    end
  end

  wire rise_a = sync_a_reg[1] & ~sync_a_reg[2];
  wire fall_a = ~sync_a_reg[1] & sync_a_reg[2];
  wire rise_b = sync_b_reg[1] & ~sync_b_reg[2];
  wire fall_b = ~sync_b_reg[1] & sync_b_reg[2];
  wire rise_x = sync_x_reg[1] & ~sync_x_reg[2];
  wire fall_x = ~sync_x_reg[1] & sync_x_reg[2];

  // capture events from the selected edge
  wire cap_a_ev = mode_reg.edge_select_a ? rise_a : fall_a;
  wire cap_b_ev = mode_reg.edge_select_b ? rise_b : fall_b;

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  wire wr       = req.sel & req.wr;
  wire wr_cmp_a = wr & (req.addr == `OFS_CMP_A);
  wire wr_cmp_b = wr & (req.addr == `OFS_CMP_B);
  wire wr_cnt   = wr & (req.addr == `OFS_COUNTER);
  wire wr_mode  = wr & (req.addr == `OFS_MODE);
  wire wr_irqp  = wr & (req.addr == `OFS_IRQ_PRE);
  wire wr_flags = wr & (req.addr == `OFS_FLAGS);

  // reserved bits are dropped on write so they always read zero
  wire [15:0] mode_wval = req.wdata & `MODE_WR_MASK;
  wire [15:0] irqp_wval = req.wdata & `IRQ_PRE_WR_MASK;
  wire        force_a   = wr_mode & req.wdata[10];
  wire        force_b   = wr_mode & req.wdata[11];

  // ----------------------------------------------------------------
  // timer clock: prescaler or external edge
  // ----------------------------------------------------------------
  wire pre_wrap = (pre_reg >= irqp_reg.prescale_factor);
  wire ext_tick = mode_reg.ext_clock_edge ? rise_x : fall_x;
  wire tick     = mode_reg.ext_clock_select ? ext_tick : pre_wrap;
  wire step     = tick & mode_reg.count_en;

  // pwm takes precedence over single-pulse only while force-A is clear
  wire pwm_on = mode_reg.pwm_mode & ~(mode_reg.single_pulse_mode & fa_keep_reg);
  wire opm_on = mode_reg.single_pulse_mode & ~pwm_on;

  // ----------------------------------------------------------------
  // compare and counter next value
  // ----------------------------------------------------------------
  wire match_a  = (count_reg == cmp_a_reg);
  wire match_b  = (count_reg == cmp_b_reg);
  wire wrap     = step & (count_reg == `COUNTER_TOP);
  wire opm_trig = opm_on & cap_a_ev;
  wire meas_clr = mode_reg.pulse_measure_mode & cap_a_ev;

  logic [15:0] count_next;
  always_comb begin
    count_next = count_reg;
    if (wr_cnt) begin
      count_next = `COUNTER_RELOAD;
    end else if (meas_clr) begin
      count_next = 16'h0000;
    end else if (opm_trig) begin
      count_next = `COUNTER_RELOAD;
    end else if (pwm_on & match_b & step) begin
      count_next = `COUNTER_RELOAD;
    end else if (step) begin
      count_next = count_reg + 16'h0001;
    end
  end

  // prescaler restarts at or above the factor, so a smaller factor takes hold at once
  always_ff @(posedge clk) begin
    if (rst) begin
      pre_reg <= 8'h00;
    end else if (ce) begin
      pre_reg <= pre_wrap ? 8'h00 : pre_reg + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= `COUNTER_RELOAD;
    end else if (ce) begin
      count_reg <= count_next;
    end
  end

  // ----------------------------------------------------------------
  // control and compare registers
  // ----------------------------------------------------------------
  // force bits are one-shot actions; the mode register does not keep them set
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_reg  <= `MODE_RESET;
      irqp_reg  <= `IRQ_PRE_RESET;
      cmp_a_reg <= `CMP_A_RESET;
      cmp_b_reg <= 16'h0000;
    end else if (ce) begin
      if (wr_mode) mode_reg <= mode_wval & 16'hf3ff;
      if (wr_irqp) irqp_reg <= irqp_wval;
      if (wr_cmp_a) cmp_a_reg <= req.wdata;
      if (wr_cmp_b) cmp_b_reg <= req.wdata;
    end
  end

  // force-A is kept as pwm/opm arbitration input
  always_ff @(posedge clk) begin
    if (rst) begin
      fa_keep_reg <= 1'b0;
    end else if (ce && wr_mode) begin
      fa_keep_reg <= req.wdata[10];
    end
  end

  // ----------------------------------------------------------------
  // capture registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      cap_a_reg <= 16'h0000;
      cap_b_reg <= 16'h0000;
    end else if (ce) begin
      if (cap_a_ev) cap_a_reg <= count_reg;
      if (cap_b_ev) cap_b_reg <= count_reg;
    end
  end

  // ----------------------------------------------------------------
  // output waveforms
  // ----------------------------------------------------------------
  // a match is acted on only in a timer clock, so a held count fires once
  wire ev_a = match_a & step;
  wire ev_b = match_b & step;
  wire wave = pwm_on | opm_on;

  logic out_a_next;
  logic out_b_next;
  // a force applies the level written in the same access, not the stale one
  always_comb begin
    out_a_next = out_a_reg;
    out_b_next = out_b_reg;
    if (force_a) begin
      out_a_next = req.wdata[8];
    end else if (opm_trig) begin
      out_a_next = mode_reg.level_b;
    end else if (wave & ev_a & (pwm_on | pulse_run_reg)) begin
      out_a_next = mode_reg.level_a;
    end else if (pwm_on & ev_b) begin
      out_a_next = mode_reg.level_b;
    end else if (~wave & ev_a) begin
      out_a_next = mode_reg.level_a;
    end
    if (force_b) begin
      out_b_next = req.wdata[9];
    end else if (~wave & ev_b) begin
      out_b_next = mode_reg.level_b;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      out_a_reg     <= 1'b0;
      out_b_reg     <= 1'b0;
      pulse_run_reg <= 1'b0;
    end else if (ce) begin
      out_a_reg <= out_a_next;
      out_b_reg <= out_b_next;
      if (opm_trig) pulse_run_reg <= 1'b1;
      else if (ev_a) pulse_run_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // event flags: hardware set wins over a software clear
  // ----------------------------------------------------------------
  logic [15:0] set_vec;
  always_comb begin
    set_vec = 16'h0000;
    set_vec[`BIT_CAP_A] = cap_a_ev & ~(mode_reg.pulse_measure_mode & first_cap_reg);
    set_vec[`BIT_CMP_A] = ev_a & ~pwm_on;
    set_vec[`BIT_OVF]   = wrap;
    set_vec[`BIT_CAP_B] = cap_b_ev;
    set_vec[`BIT_CMP_B] = ev_b;
  end

  wire [15:0] clr_vec   = wr_flags ? ~req.wdata : 16'h0000;
  wire [15:0] flag_next = ((flags_reg & ~clr_vec) | set_vec) & 16'hf800;

  always_ff @(posedge clk) begin
    if (rst) begin
      flags_reg     <= 16'h0000;
      first_cap_reg <= 1'b1;
    end else if (ce) begin
      flags_reg <= flag_next;
      if (~mode_reg.pulse_measure_mode) first_cap_reg <= 1'b1;
      else if (cap_a_ev) first_cap_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read mux and registered outputs
  // ----------------------------------------------------------------
  logic [15:0] rd_mux;
  always_comb begin
    unique case (req.addr)
      `OFS_CAP_A:   rd_mux = cap_a_reg;
      `OFS_CAP_B:   rd_mux = cap_b_reg;
      `OFS_CMP_A:   rd_mux = cmp_a_reg;
      `OFS_CMP_B:   rd_mux = cmp_b_reg;
      `OFS_COUNTER: rd_mux = count_reg;
      `OFS_MODE:    rd_mux = mode_reg;
      `OFS_IRQ_PRE: rd_mux = irqp_reg;
      `OFS_FLAGS:   rd_mux = flags_reg;
      default:      rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata         <= 16'h0000;
      compare_out_a <= 1'b0;
      compare_out_b <= 1'b0;
      out_a_pin_sel <= 1'b0;
      out_b_pin_sel <= 1'b0;
      irq_cap_a     <= 1'b0;
      irq_cmp_a     <= 1'b0;
      irq_overflow  <= 1'b0;
      irq_cap_b     <= 1'b0;
      irq_cmp_b     <= 1'b0;
    end else if (ce) begin
      rdata         <= req.sel ? rd_mux : 16'h0000;
      compare_out_a <= out_a_next;
      compare_out_b <= out_b_next;
      out_a_pin_sel <= mode_reg.out_a_pin_enable;
      out_b_pin_sel <= mode_reg.out_b_pin_enable;
      irq_cap_a     <= irqp_reg.cap_a_irq_en & flag_next[`BIT_CAP_A];
      irq_cmp_a     <= irqp_reg.cmp_a_irq_en & flag_next[`BIT_CMP_A];
      irq_overflow  <= irqp_reg.overflow_irq_en & flag_next[`BIT_OVF];
      irq_cap_b     <= irqp_reg.cap_b_irq_en & flag_next[`BIT_CAP_B];
      irq_cmp_b     <= irqp_reg.cmp_b_irq_en & flag_next[`BIT_CMP_B];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_count_reload: assert property (@(posedge clk) disable iff (rst)
    ce && wr_cnt |=> count_reg == 16'hfffc)
    else $error("counter not reloaded after write");

  a_count_hold: assert property (@(posedge clk) disable iff (rst)
    ce && !mode_reg.count_en && !wr_cnt && !meas_clr && !opm_trig |=> $stable(count_reg))
    else $error("counter moved while disabled");

  a_count_step: assert property (@(posedge clk) disable iff (rst)
    ce && step && !wr_cnt && !meas_clr && !opm_trig && !(pwm_on && match_b)
    |=> count_reg == $past(count_reg) + 16'h0001)
    else $error("counter did not step by one");

  a_ovf_flag: assert property (@(posedge clk) disable iff (rst)
    ce && wrap |=> flags_reg[13])
    else $error("overflow flag missed");

  a_cmpa_pwm: assert property (@(posedge clk) disable iff (rst)
    ce && pwm_on && !flags_reg[14] |=> !flags_reg[14])
    else $error("compare A flag set in pwm mode");

  a_cmpb_flag: assert property (@(posedge clk) disable iff (rst)
    ce && ev_b |=> flags_reg[11])
    else $error("compare B flag missed");

  a_flag_clear: assert property (@(posedge clk) disable iff (rst)
    ce && wr_flags && !req.wdata[12] && !cap_b_ev |=> !flags_reg[12])
    else $error("capture B flag not cleared");

  a_force_b: assert property (@(posedge clk) disable iff (rst)
    ce && force_b |=> compare_out_b == mode_reg.level_b)
    else $error("force B did not drive level");

  a_capture_latch: assert property (@(posedge clk) disable iff (rst)
    ce && cap_b_ev |=> cap_b_reg == $past(count_reg))
    else $error("capture B did not latch count");

  a_meas_clear: assert property (@(posedge clk) disable iff (rst)
    ce && meas_clr && !wr_cnt |=> count_reg == 16'h0000)
    else $error("measurement capture did not clear counter");

  a_pwm_period: assert property (@(posedge clk) disable iff (rst)
    ce && pwm_on && ev_b && !wr_cnt && !meas_clr |=> count_reg == 16'hfffc)
    else $error("pwm period did not restart");
endmodule

`default_nettype wire

//--- tb/timer_pins_model.sv
// outside-world model of the timer pins: capture inputs, external clock, waveform watch
`timescale 1ns/10ps
`default_nettype none

module timer_pins_model (
  // bench clock
  input  wire logic clk,
  // waveform output watched from outside
  input  wire logic compare_out_a,
  // pins driven from outside
  output var  logic capture_in_a,
  output var  logic capture_in_b,
  output var  logic external_clock_in
);
  int rises_a;

  // pins idle low; external clock stands still until pulses are asked for
  initial begin
    capture_in_a = 1'b0;
    capture_in_b = 1'b0;
    external_clock_in = 1'b0;
    rises_a = 0;
  end

  // count waveform periods seen on output a
  always @(posedge compare_out_a) rises_a++;

  // change one capture pin just after an edge; held until told otherwise
  task automatic drive_cap(input int ch, input logic lvl);
    @(posedge clk);
    #1;
    if (ch == 0) capture_in_a = lvl;
    else capture_in_b = lvl;
  endtask

  // each level held four cycles so the two-flop synchroniser never misses one
  task automatic ext_toggle(input int k);
    repeat (k) begin
      @(posedge clk);
      #1;
      external_clock_in = ~external_clock_in;
      repeat (3) @(posedge clk);
    end
  endtask
endmodule

`default_nettype wire

//--- tb/capture_compare_timer_regs_tb.sv
// self-checking bench for the capture/compare timer with its pin model
`timescale 1ns/10ps
`default_nettype none
`include "timer_params.svh"

module capture_compare_timer_regs_tb;
  import timer_pkg::*;
  localparam logic [15:0] reset_table [8] = '{16'h0000, 16'h0000, 16'h8000, 16'h0000,
                                             16'hfffc, 16'h0000, 16'h0000, 16'h0000};
  logic        clk;
  logic        rst;
  reg_req_s    req;
  logic [15:0] rdata;
  wire logic   cap_a, cap_b, ext_clk, out_a, out_b, sel_a, sel_b;
  wire logic   [4:0] irq;
  int          num_errors;
  int          checked;
  int          model [logic [7:0]];
  logic [15:0] v0, v1;
  int          p, k;

  capture_compare_timer_regs capture_compare_timer_regs_i (
    .clk(clk), .rst(rst), .ce(1'b1), .req(req), .rdata(rdata),
    .capture_in_a(cap_a), .capture_in_b(cap_b), .external_clock_in(ext_clk),
    .compare_out_a(out_a), .compare_out_b(out_b), .out_a_pin_sel(sel_a), .out_b_pin_sel(sel_b),
    .irq_cap_a(irq[4]), .irq_cmp_a(irq[3]), .irq_overflow(irq[2]), .irq_cap_b(irq[1]),
    .irq_cmp_b(irq[0]));

  timer_pins_model timer_pins_model_i (
    .clk(clk), .compare_out_a(out_a), .capture_in_a(cap_a), .capture_in_b(cap_b),
    .external_clock_in(ext_clk));

  // ----------------------------------------
  // bus tasks, comparison and verdict
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // write one register; the shadow keeps only bits that read back
  // an idle edge follows, so a next access never re-raises sel in the same step
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    req = '{sel: 1'b1, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk);
    #1;
    req.sel = 1'b0;
    if (a == `OFS_MODE) model[a] = d & 16'hc3ff;
    else if (a == `OFS_IRQ_PRE) model[a] = d & 16'hf8ff;
    else if (a == `OFS_CMP_A || a == `OFS_CMP_B) model[a] = d;
    @(posedge clk);
    #1;
  endtask

  // rdata is registered by the taking edge, so it is read just after it
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    req = '{sel: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
    @(posedge clk);
    #1;
    req.sel = 1'b0;
    d = rdata;
    @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rc(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    chk(d, exp);
  endtask

  task automatic report_and_stop;
    if (num_errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // watchdog: about forty times the expected run length
  initial begin
    #1000000;
    num_errors++;
    report_and_stop();
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(32'hccc9499c));
    rst = 1'b1;
    req = '0;
    num_errors = 0;
    checked = 0;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    // reset values, then an unmapped offset
    foreach (reset_table[i]) rc(8'(i * 4), reset_table[i]);
    rc(8'h20, 16'h0000);
    // reserved bits dropped, capture registers ignore writes
    wr(`OFS_MODE, 16'h30c0);
    wr(`OFS_IRQ_PRE, 16'hffff);
    wr(`OFS_CMP_A, 16'($urandom));
    wr(`OFS_CMP_B, 16'($urandom));
    wr(`OFS_CAP_A, 16'h1234);
    for (int a = 8; a <= 24; a += 4) if (a != 16) rc(8'(a), 16'(model[8'(a)]));
    rc(`OFS_CAP_A, 16'h0000);
    chk({14'h0, sel_b, sel_a}, 16'h0003);
    chk({11'h0, irq}, 16'h0000);
    // counter write reload and hold while disabled
    wr(`OFS_MODE, 16'h0000);
    wr(`OFS_COUNTER, 16'($urandom));
    rc(`OFS_COUNTER, 16'hfffc);
    cyc(20);
    rc(`OFS_COUNTER, 16'hfffc);
    // two reads 4*(p+1) cycles apart see exactly four steps
    p = $urandom % 8;
    wr(`OFS_IRQ_PRE, 16'(p));
    wr(`OFS_MODE, 16'h8000);
    rd(`OFS_COUNTER, v0);
    cyc(4 * p + 2);
    rd(`OFS_COUNTER, v1);
    chk(v1 - v0, 16'h0004);
    // wrap, both compare matches, overflow interrupt, clear by zero
    wr(`OFS_MODE, 16'h0000);
    wr(`OFS_IRQ_PRE, 16'hf800);
    wr(`OFS_CMP_A, 16'h0003);
    wr(`OFS_CMP_B, 16'h0001);
    wr(`OFS_FLAGS, 16'h0000);
    wr(`OFS_COUNTER, 16'($urandom));
    wr(`OFS_MODE, 16'h83c0);
    cyc(12);
    wr(`OFS_MODE, 16'h0000);
    rc(`OFS_FLAGS, 16'h6800);
    chk({14'h0, out_b, out_a}, 16'h0003);
    chk({11'h0, irq}, 16'h000d);
    wr(`OFS_FLAGS, 16'hdfff);
    rc(`OFS_FLAGS, 16'h4800);
    chk({11'h0, irq}, 16'h0009);
    wr(`OFS_FLAGS, 16'h0000);
    // pwm: waveform on a, no compare-a flag, compare-b reload
    timer_pins_model_i.rises_a = 0;
    wr(`OFS_CMP_B, 16'h0006);
    wr(`OFS_COUNTER, 16'h0000);
    wr(`OFS_MODE, 16'h8250);
    cyc(60);
    wr(`OFS_MODE, 16'h0000);
    rc(`OFS_FLAGS, 16'h2800);
    chk(16'(timer_pins_model_i.rises_a >= 3), 16'h0001);
    rd(`OFS_COUNTER, v0);
    chk(16'(v0 <= 16'h0006 || v0 >= 16'hfffc), 16'h0001);
    // forced levels, then writing force bits as zero changes nothing
    foreach (reset_table[i]) if (i < 3) begin
      wr(`OFS_MODE, i == 0 ? 16'h0fc0 : i == 1 ? 16'h0cc0 : 16'h03c0);
      cyc(3);
      chk({14'h0, out_b, out_a}, i == 0 ? 16'h0003 : 16'h0000);
      rc(`OFS_MODE, 16'(model[`OFS_MODE]));
    end
    // captures on the selected edge latch the stopped counter
    wr(`OFS_COUNTER, 16'($urandom));
    for (int e = 0; e < 2; e++) begin
      wr(`OFS_MODE, e ? 16'h000c : 16'h0000);
      wr(`OFS_FLAGS, 16'h0000);
      timer_pins_model_i.drive_cap(0, !e);
      timer_pins_model_i.drive_cap(1, !e);
      cyc(5);
      rc(`OFS_FLAGS, 16'h0000);
      timer_pins_model_i.drive_cap(0, e);
      timer_pins_model_i.drive_cap(1, e);
      cyc(5);
      rc(`OFS_FLAGS, 16'h9000);
      chk({11'h0, irq}, 16'h0012);
      rc(`OFS_CAP_A, 16'hfffc);
      rc(`OFS_CAP_B, 16'hfffc);
    end
    // external clock on either edge, and held while counting is off
    for (int e = 0; e < 3; e++) begin
      k = 2 * ($urandom % 4) + 3;
      wr(`OFS_MODE, (e < 2 ? 16'h8001 : 16'h0001) | (e == 1 ? 16'h0002 : 16'h0000));
      cyc(4);
      wr(`OFS_COUNTER, 16'h0000);
      timer_pins_model_i.ext_toggle(k);
      cyc(4);
      rc(`OFS_COUNTER, e == 2 ? 16'hfffc : 16'hfffc + 16'(k / 2 + e));
      timer_pins_model_i.ext_toggle(1);
    end
    // measurement mode: first capture clears the counter silently, second flags and latches
    timer_pins_model_i.drive_cap(0, 1'b0); // pin starts low so the first rise is real
    cyc(5);
    wr(`OFS_MODE, 16'hc004);
    wr(`OFS_IRQ_PRE, 16'h8000);
    wr(`OFS_FLAGS, 16'h0000);
    timer_pins_model_i.drive_cap(0, 1'b1);
    cyc(5);
    rd(`OFS_FLAGS, v0);
    chk(v0 & 16'h8000, 16'h0000);
    timer_pins_model_i.drive_cap(0, 1'b0);
    cyc(8);
    timer_pins_model_i.drive_cap(0, 1'b1);
    cyc(5);
    rd(`OFS_FLAGS, v0);
    chk(v0 & 16'h8000, 16'h8000);
    chk({15'h0, irq[4]}, 16'h0001);
    rd(`OFS_CAP_A, v1);
    chk(16'(v1 >= 16'd13 && v1 <= 16'd18), 16'h0001);
    // single pulse from a rising edge on capture a
    wr(`OFS_MODE, 16'h8264);
    wr(`OFS_CMP_A, 16'h0010);
    wr(`OFS_COUNTER, 16'h0000);
    timer_pins_model_i.drive_cap(0, 1'b0);
    cyc(3);
    chk({15'h0, out_a}, 16'h0000);
    timer_pins_model_i.drive_cap(0, 1'b1);
    cyc(6);
    chk({15'h0, out_a}, 16'h0001);
    cyc(60);
    chk({15'h0, out_a}, 16'h0000);
    report_and_stop();
  end
endmodule

`default_nettype wire
